// [rtl/mahm_mdio.sv]
// Purpose: Runs one management frame to the PHY per start pulse.
// Assumes: start only arrives while idle.
// Notes: MDC low phase drives, high phase samples; read data taken on rising MDC.
module mahm_mdio #(
  parameter int HALF_CYC = mahm_pkg::MDC_HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic writeSel,
  input wire logic [4:0] phyAddr,
  input wire logic [4:0] regIdx,
  input wire logic [15:0] wrData,
  output logic done,
  output logic [15:0] rdData,
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe
);
  localparam int FRAME_MAX = 700;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  mahm_pkg::mahm_state_t state_reg, state_next;
  logic [7:0] div_reg, div_next;
  logic [6:0] bit_reg, bit_next;
  logic [63:0] shift_reg, shift_next;
  logic [15:0] rd_reg, rd_next;
  logic wr_reg, wr_next;
  logic mdc_reg, mdc_next;
  logic out_reg, out_next;
  logic oe_reg, oe_next;
  logic done_reg, done_next;
  logic syncA_reg, syncB_reg;
  logic tick;

  always_comb begin
    state_next = state_reg;
    div_next = div_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    rd_next = rd_reg;
    wr_next = wr_reg;
    mdc_next = mdc_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    done_next = 1'b0;
    tick = (div_reg == HALF_LAST);
    unique case (state_reg)
      mahm_pkg::MAHM_IDLE: begin
        if (start) begin
          shift_next = {mahm_pkg::PREAMBLE, mahm_pkg::FRAME_START,
                        writeSel ? mahm_pkg::OP_WRITE : mahm_pkg::OP_READ,
                        phyAddr, regIdx,
                        writeSel ? mahm_pkg::TA_WRITE : mahm_pkg::TA_READ,
                        writeSel ? wrData : 16'h0000};
          wr_next = writeSel;
          bit_next = 7'h00;
          div_next = 8'h00;
          mdc_next = 1'b0;
          out_next = 1'b1;
          oe_next = 1'b1;
          state_next = mahm_pkg::MAHM_RUN;
        end
      end
      mahm_pkg::MAHM_RUN: begin
        div_next = tick ? 8'h00 : 8'(div_reg + 8'h01);
        if (tick) begin
          mdc_next = ~mdc_reg;
          if (!mdc_reg) begin
            if (!wr_reg && bit_reg >= mahm_pkg::DATA_FIRST_BIT) begin
              rd_next = {rd_reg[14:0], syncB_reg};
            end
          end else if (bit_reg == mahm_pkg::FRAME_BITS - 7'h01) begin
            state_next = mahm_pkg::MAHM_IDLE;
            oe_next = 1'b0;
            out_next = 1'b0;
            done_next = 1'b1;
          end else begin
            bit_next = 7'(bit_reg + 7'h01);
            shift_next = {shift_reg[62:0], 1'b0};
            out_next = shift_reg[62];
            oe_next = wr_reg || (7'(bit_reg + 7'h01) < mahm_pkg::DRIVE_READ_BITS);
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= mahm_pkg::MAHM_IDLE;
      div_reg <= 8'h00;
      bit_reg <= 7'h00;
      shift_reg <= 64'h0;
      rd_reg <= 16'h0000;
      wr_reg <= 1'b0;
      mdc_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      done_reg <= 1'b0;
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      mdc_reg <= mdc_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      done_reg <= done_next;
      syncA_reg <= mdioIn;
      syncB_reg <= syncA_reg;
    end
  end

  assign done = done_reg;
  assign rdData = rd_reg;
  assign mdc = mdc_reg;
  assign mdioOut = out_reg;
  assign mdioOe = oe_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  frame_bounded_a: assert property (start && state_reg == mahm_pkg::MAHM_IDLE
      |-> ##[1:FRAME_MAX] done_reg)
    else $error("management frame did not finish in time");
  read_release_a: assert property (!wr_reg && state_reg == mahm_pkg::MAHM_RUN
      && bit_reg >= mahm_pkg::DRIVE_READ_BITS |-> !oe_reg)
    else $error("line driven during read turnaround or data");
endmodule : mahm_mdio

// [rtl/mahm_pkg.sv]
// Purpose: Shared constants for the station address, hash filter and PHY management registers.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes: Single clock mclk at 25 MHz.
package mahm_pkg;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  localparam logic [IDX_W-1:0] IDX_ADDR_HIGH = 6'h02;
  localparam logic [IDX_W-1:0] IDX_ADDR_LOW = 6'h03;
  localparam logic [IDX_W-1:0] IDX_HASH_UPPER = 6'h04;
  localparam logic [IDX_W-1:0] IDX_HASH_LOWER = 6'h05;
  localparam logic [IDX_W-1:0] IDX_MGMT_ACCESS = 6'h06;
  localparam logic [IDX_W-1:0] IDX_MGMT_DATA = 6'h07;
  localparam logic [IDX_W-1:0] IDX_FILTER_CTRL = 6'h10;

  localparam logic [31:0] ADDR_LOW_RST = 32'h0fffffff;
  localparam logic [15:0] ADDR_HIGH_RST = 16'hffff;
  localparam logic [31:0] HASH_RST = 32'h00000000;
  localparam logic [15:0] MGMT_DATA_RST = 16'h0000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;

  localparam int ADDR_HIGH_W = 16;
  localparam int STATION_W = 48;
  localparam int STATION_BYTES = 6;
  localparam logic [7:0] CFG_BYTE_FIRST = 8'h01;

  localparam int ACC_PHY_LSB = 11;
  localparam int ACC_REG_LSB = 6;
  localparam int ACC_WRITE_BIT = 1;
  localparam int ACC_BUSY_BIT = 0;
  localparam int FIELD5_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] INTERNAL_PHY_ADDR = 5'h01;
  localparam int PASS_ALL_BIT = 0;
  localparam int HASH_IDX_W = 6;

  localparam logic [6:0] FRAME_BITS = 7'h40;
  localparam logic [6:0] DRIVE_READ_BITS = 7'h2e;
  localparam logic [6:0] DATA_FIRST_BIT = 7'h30;
  localparam logic [31:0] PREAMBLE = 32'hffffffff;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [1:0] TA_READ = 2'h0;

  localparam int CLK_NS = 40;
  localparam int MDC_HALF_NS = 200;
  localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic {
    MAHM_IDLE = 1'b0,
    MAHM_RUN = 1'b1
  } mahm_state_t;
endpackage : mahm_pkg

// [rtl/mahm_regs.sv]
// Purpose: Station address, multicast hash filter and PHY management register bank.
// Assumes: Config-memory bytes and hash lookups come from logic on mclk.
// Notes: Register byte address is four times the word index; unaligned or unmapped reads give 0.
module mahm_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic cfgByteValid,
  input wire logic [7:0] cfgByteAddr,
  input wire logic [7:0] cfgByteData,
  input wire logic cfgLoadDone,
  input wire logic hashLookup,
  input wire logic [5:0] hashIndex,
  output logic hashAccept,
  output logic hashAcceptValid,
  output logic [47:0] stationAddr,
  output logic passAllMulticast,
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe
);
  logic [31:0] addrLow_reg, addrLow_next;
  logic [15:0] addrHigh_reg, addrHigh_next;
  logic [31:0] hashUpper_reg, hashUpper_next;
  logic [31:0] hashLower_reg, hashLower_next;
  logic [4:0] phyAddr_reg, phyAddr_next;
  logic [4:0] regIdx_reg, regIdx_next;
  logic writeSel_reg, writeSel_next;
  logic busy_reg, busy_next;
  logic [15:0] data_reg, data_next;
  logic passAll_reg, passAll_next;
  logic initDone_reg, initDone_next;
  logic [31:0] rdData_reg, rdData_next;
  logic accept_reg, accept_next;
  logic acceptValid_reg, acceptValid_next;
  logic start_reg, start_next;
  logic [47:0] station;
  logic aligned;
  logic [5:0] idx;
  logic mdioDone;
  logic [15:0] mdioRdData;
  logic hashBit;

  localparam int HASH_TOP = mahm_pkg::HASH_IDX_W - 1;

  assign aligned = (regAddr[1:0] == mahm_pkg::WORD_ALIGN);
  assign idx = regAddr[7:2];

  // Register write and config load path
  always_comb begin
    station = {addrHigh_reg, addrLow_reg};
    hashUpper_next = hashUpper_reg;
    hashLower_next = hashLower_reg;
    phyAddr_next = phyAddr_reg;
    regIdx_next = regIdx_reg;
    writeSel_next = writeSel_reg;
    busy_next = busy_reg;
    data_next = data_reg;
    passAll_next = passAll_reg;
    start_next = 1'b0;
    initDone_next = initDone_reg | cfgLoadDone;
    for (int i = 0; i < mahm_pkg::STATION_BYTES; i++) begin
      if (cfgByteValid && !initDone_reg
          && cfgByteAddr == 8'(int'(mahm_pkg::CFG_BYTE_FIRST) + i)) begin
        station[i*8 +: 8] = cfgByteData;
      end
    end
    if (regWr && aligned) begin
      unique case (idx)
        mahm_pkg::IDX_ADDR_LOW: begin
          if (initDone_reg) begin
            station[31:0] = regWrData;
          end
        end
        mahm_pkg::IDX_ADDR_HIGH: begin
          if (initDone_reg) begin
            station[47:32] = regWrData[mahm_pkg::ADDR_HIGH_W-1:0];
          end
        end
        mahm_pkg::IDX_HASH_UPPER: begin
          hashUpper_next = regWrData;
        end
        mahm_pkg::IDX_HASH_LOWER: begin
          hashLower_next = regWrData;
        end
        mahm_pkg::IDX_MGMT_ACCESS: begin
          if (!busy_reg) begin
            phyAddr_next = regWrData[mahm_pkg::ACC_PHY_LSB +: mahm_pkg::FIELD5_W];
            regIdx_next = regWrData[mahm_pkg::ACC_REG_LSB +: mahm_pkg::FIELD5_W];
            writeSel_next = regWrData[mahm_pkg::ACC_WRITE_BIT];
            if (regWrData[mahm_pkg::ACC_BUSY_BIT]) begin
              busy_next = 1'b1;
              start_next = 1'b1;
            end
          end
        end
        mahm_pkg::IDX_MGMT_DATA: begin
          if (!busy_reg) begin
            data_next = regWrData[mahm_pkg::DATA_W-1:0];
          end
        end
        mahm_pkg::IDX_FILTER_CTRL: begin
          passAll_next = regWrData[mahm_pkg::PASS_ALL_BIT];
        end
        default: begin
        end
      endcase
    end
    // completion clears busy, read result lands
    if (mdioDone) begin
      busy_next = 1'b0;
      if (!writeSel_reg) begin
        data_next = mdioRdData;
      end
    end
    addrLow_next = station[31:0];
    addrHigh_next = station[47:32];
  end

  // Read data path, valid only in the cycle after the strobe
  always_comb begin
    rdData_next = mahm_pkg::ZERO_WORD;
    if (regRd && aligned) begin
      unique case (idx)
        mahm_pkg::IDX_ADDR_LOW: begin
          rdData_next = addrLow_reg;
        end
        mahm_pkg::IDX_ADDR_HIGH: begin
          rdData_next = {16'h0000, addrHigh_reg};
        end
        mahm_pkg::IDX_HASH_UPPER: begin
          rdData_next = hashUpper_reg;
        end
        mahm_pkg::IDX_HASH_LOWER: begin
          rdData_next = hashLower_reg;
        end
        mahm_pkg::IDX_MGMT_ACCESS: begin
          rdData_next = {16'h0000, phyAddr_reg, regIdx_reg, 4'h0, writeSel_reg, busy_reg};
        end
        mahm_pkg::IDX_MGMT_DATA: begin
          rdData_next = {16'h0000, data_reg};
        end
        mahm_pkg::IDX_FILTER_CTRL: begin
          rdData_next = {31'h00000000, passAll_reg};
        end
        default: begin
        end
      endcase
    end
  end

  // Hash lookup
  always_comb begin
    // index selects table half and bit
    hashBit = hashIndex[HASH_TOP] ? hashUpper_reg[hashIndex[4:0]] : hashLower_reg[hashIndex[4:0]];
    accept_next = accept_reg;
    acceptValid_next = hashLookup;
    if (hashLookup) begin
      accept_next = passAll_reg | hashBit;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      addrLow_reg <= mahm_pkg::ADDR_LOW_RST;
      addrHigh_reg <= mahm_pkg::ADDR_HIGH_RST;
      hashUpper_reg <= mahm_pkg::HASH_RST;
      hashLower_reg <= mahm_pkg::HASH_RST;
      phyAddr_reg <= 5'h00;
      regIdx_reg <= 5'h00;
      writeSel_reg <= 1'b0;
      busy_reg <= 1'b0;
      data_reg <= mahm_pkg::MGMT_DATA_RST;
      passAll_reg <= 1'b0;
      initDone_reg <= 1'b0;
      rdData_reg <= mahm_pkg::ZERO_WORD;
      accept_reg <= 1'b0;
      acceptValid_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      addrLow_reg <= addrLow_next;
      addrHigh_reg <= addrHigh_next;
      hashUpper_reg <= hashUpper_next;
      hashLower_reg <= hashLower_next;
      phyAddr_reg <= phyAddr_next;
      regIdx_reg <= regIdx_next;
      writeSel_reg <= writeSel_next;
      busy_reg <= busy_next;
      data_reg <= data_next;
      passAll_reg <= passAll_next;
      initDone_reg <= initDone_next;
      rdData_reg <= rdData_next;
      accept_reg <= accept_next;
      acceptValid_reg <= acceptValid_next;
      start_reg <= start_next;
    end
  end

  mahm_mdio u_mdio (
    .mclk(mclk),
    .rst(rst),
    .start(start_reg),
    .writeSel(writeSel_reg),
    .phyAddr(phyAddr_reg),
    .regIdx(regIdx_reg),
    .wrData(data_reg),
    .done(mdioDone),
    .rdData(mdioRdData),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe)
  );

  assign regRdData = rdData_reg;
  assign hashAccept = accept_reg;
  assign hashAcceptValid = acceptValid_reg;
  assign stationAddr = {addrHigh_reg, addrLow_reg};
  assign passAllMulticast = passAll_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  low_read_a: assert property (regRd && aligned && idx == mahm_pkg::IDX_ADDR_LOW
      |=> regRdData == $past(addrLow_reg))
    else $error("address-low read mismatch");
  first_byte_a: assert property (cfgByteValid && !initDone_reg && cfgByteAddr == 8'h01
      |=> addrLow_reg[7:0] == $past(cfgByteData))
    else $error("config byte 1 not in address-low bits 7:0");
  second_byte_a: assert property (cfgByteValid && !initDone_reg && cfgByteAddr == 8'h02
      |=> addrLow_reg[15:8] == $past(cfgByteData))
    else $error("config byte 2 not in address-low bits 15:8");
  third_byte_a: assert property (cfgByteValid && !initDone_reg && cfgByteAddr == 8'h03
      |=> addrLow_reg[23:16] == $past(cfgByteData))
    else $error("config byte 3 not in address-low bits 23:16");
  fourth_byte_a: assert property (cfgByteValid && !initDone_reg && cfgByteAddr == 8'h04
      |=> addrLow_reg[31:24] == $past(cfgByteData))
    else $error("config byte 4 not in address-low top byte");
  fifth_byte_a: assert property (cfgByteValid && !initDone_reg && cfgByteAddr == 8'h05
      |=> addrHigh_reg[7:0] == $past(cfgByteData))
    else $error("config byte 5 not in address-high bits 7:0");
  sixth_byte_a: assert property (cfgByteValid && !initDone_reg && cfgByteAddr == 8'h06
      |=> addrHigh_reg[15:8] == $past(cfgByteData))
    else $error("config byte 6 not in address-high bits 15:8");
  init_lock_a: assert property (!initDone_reg && !cfgByteValid
      |=> $stable(addrLow_reg) && $stable(addrHigh_reg))
    else $error("address changed before init without load");
  hash_pick_a: assert property (hashLookup && !passAll_reg
      |=> hashAccept == $past(hashIndex[5] ? hashUpper_reg[hashIndex[4:0]]
          : hashLower_reg[hashIndex[4:0]]) && hashAcceptValid)
    else $error("hash accept does not follow table bit");
  pass_all_a: assert property (hashLookup && passAll_reg |=> hashAccept)
    else $error("pass-all multicast did not accept");
  hash_reset_a: assert property ($past(rst) |-> hashUpper_reg == 32'h0
      && hashLower_reg == 32'h0 && addrHigh_reg == 16'hffff)
    else $error("hash or address-high reset value wrong");
  busy_start_a: assert property (start_reg |-> busy_reg ##1 busy_reg)
    else $error("busy not held at start of access");
  busy_end_a: assert property (mdioDone |=> !busy_reg)
    else $error("busy not cleared at completion");
  data_hold_a: assert property (busy_reg && writeSel_reg |=> $stable(data_reg))
    else $error("data changed during PHY write");
  resv_read_a: assert property (regRd && aligned && idx == mahm_pkg::IDX_MGMT_DATA
      |=> regRdData[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");
  high_read_a: assert property (regRd && aligned && idx == mahm_pkg::IDX_ADDR_HIGH
      |=> regRdData == {16'h0000, $past(addrHigh_reg)})
    else $error("address-high read mismatch");
  busy_read_a: assert property (regRd && aligned && idx == mahm_pkg::IDX_MGMT_ACCESS
      |=> regRdData[0] == $past(busy_reg))
    else $error("busy bit read does not follow access state");
endmodule : mahm_regs

// [tb/mahm_phy_model.sv]
// Purpose: Behavioural PHY management slave with a 32-word register file.
// Assumes: Line has a pull-up; frames are sampled on rising mdc.
// Notes: Answers reads only at its own address; drives on falling mdc.
module mahm_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic mdc,
  input wire logic mdioLine,
  output logic phyOut,
  output logic phyOe,
  output logic [7:0] frameCount,
  output logic [7:0] lastPreamble,
  output logic [31:0] lastFrame
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regFile [32];
  logic [31:0] frame = 32'h0;
  logic [15:0] rdWord = 16'h0;
  int bitCnt = 0;
  int ones = 0;
  bit inFrame = 1'b0;
  bit rdAct = 1'b0;
  initial begin
    phyOut = 1'b0;
    phyOe = 1'b0;
    frameCount = 8'h00;
    lastPreamble = 8'h00;
    lastFrame = 32'h0;
    foreach (regFile[i]) regFile[i] = 16'h0000;
  end
  always @(posedge mdc) begin
    if (!inFrame) begin
      if (mdioLine === 1'b1) ones = ones + 1;
      else begin
        inFrame = 1'b1;
        rdAct = 1'b0;
        bitCnt = 1;
        frame = 32'h0;
        lastPreamble = 8'(ones);
        ones = 0;
      end
    end else begin
      frame = {frame[30:0], mdioLine};
      bitCnt = bitCnt + 1;
      if (bitCnt == 14) rdAct = frame[11:10] == 2'b10 && frame[9:5] == PHY_ADDR;
      if (bitCnt == 14) rdWord = regFile[frame[4:0]];
      if (bitCnt == 32) begin
        inFrame = 1'b0;
        frameCount = frameCount + 8'h01;
        lastFrame = frame;
        if (frame[29:28] == 2'b01 && frame[27:23] == PHY_ADDR) regFile[frame[22:18]] = frame[15:0];
      end
    end
  end
  always @(negedge mdc) begin
    phyOe = rdAct && inFrame && bitCnt >= 15;
    phyOut = (bitCnt >= 16 && bitCnt <= 31) ? rdWord[31 - bitCnt] : 1'b0;
  end
endmodule : mahm_phy_model

// [tb/mahm_regs_test.sv]
// Purpose: Self-checking bench for the address, hash and PHY management registers.
// Assumes: Bus tasks leave one idle cycle between strobes.
// Notes: Read and lookup results are checked from note queues by a monitor.
module mahm_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] v; bit any;} mahm_note_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic cfgByteValid = 1'b0;
  logic [7:0] cfgByteAddr = 8'h00;
  logic [7:0] cfgByteData = 8'h00;
  logic cfgLoadDone = 1'b0;
  logic hashLookup = 1'b0;
  logic [5:0] hashIndex = 6'h00;
  logic hashAccept, hashAcceptValid, passAllMulticast, mdc, mdioOut, mdioOe, phyOut, phyOe;
  logic [47:0] stationAddr;
  logic [7:0] frameCount, lastPreamble, frames = 8'h00;
  logic [31:0] lastFrame, up, lo, d, tmp;
  wire mdioLine = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
  mahm_note_t rq[$];
  mahm_note_t note;
  logic hq[$];
  logic rdSeen = 1'b0;
  logic lkSeen = 1'b0;
  int fails = 0;
  int totalChecks = 0;
  logic [7:0] rstAddr [9] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h40, 8'h20, 8'h0d};
  logic [31:0] rstVal [9] = '{32'h0000ffff, 32'h0fffffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0};
  mahm_regs dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cfgByteValid(cfgByteValid),
    .cfgByteAddr(cfgByteAddr), .cfgByteData(cfgByteData), .cfgLoadDone(cfgLoadDone),
    .hashLookup(hashLookup), .hashIndex(hashIndex), .hashAccept(hashAccept),
    .hashAcceptValid(hashAcceptValid), .stationAddr(stationAddr),
    .passAllMulticast(passAllMulticast), .mdc(mdc), .mdioIn(mdioLine), .mdioOut(mdioOut),
    .mdioOe(mdioOe));
  mahm_phy_model phy (.mdc(mdc), .mdioLine(mdioLine), .phyOut(phyOut), .phyOe(phyOe),
    .frameCount(frameCount), .lastPreamble(lastPreamble), .lastFrame(lastFrame));
  always #20 mclk = ~mclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic strobe_rd(input logic [7:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
  endtask : strobe_rd
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back('{e, 1'b0});
    strobe_rd(a);
  endtask : rd
  task automatic cfg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    cfgByteValid <= 1'b1;
    cfgByteAddr <= a;
    cfgByteData <= v;
    @(posedge mclk);
    cfgByteValid <= 1'b0;
  endtask : cfg
  task automatic sta(input logic [47:0] e);
    check(stationAddr[31:0], e[31:0], "station low");
    check({16'h0, stationAddr[47:32]}, {16'h0, e[47:32]}, "station high");
  endtask : sta
  task automatic lookups(input logic [31:0] u, input logic [31:0] l, input logic pa);
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      hashLookup <= 1'b1;
      hashIndex <= 6'(i);
      hq.push_back(pa | (i[5] ? u[i[4:0]] : l[i[4:0]]));
    end
    @(posedge mclk);
    hashLookup <= 1'b0;
  endtask : lookups
  task automatic mgmt(input logic [4:0] pa, input logic [4:0] rg, input logic ws,
      input logic [31:0] dExp, input logic [31:0] fExp);
    logic [31:0] acc, v;
    int n;
    acc = {16'h0, pa, rg, 4'h0, ws, 1'b1};
    v = 32'h1;
    n = 0;
    wr(8'h18, acc | 32'hffff003c);
    rd(8'h18, acc);
    wr(8'h18, 32'h0);
    if (ws) wr(8'h1c, 32'h00001111);
    if (ws) rd(8'h1c, dExp);
    while (v[0] !== 1'b0 && n < 2000) begin
      rq.push_back('{32'h0, 1'b1});
      strobe_rd(8'h18);
      @(negedge mclk);
      v = regRdData;
      n++;
    end
    check({31'h0, v[0]}, 32'h0, "busy clear");
    rd(8'h18, {acc[31:1], 1'b0});
    rd(8'h1c, dExp);
    frames = frames + 8'h01;
    check({24'h0, frameCount}, {24'h0, frames}, "frame count");
    check(lastFrame, fExp, "frame bits");
    check({24'h0, lastPreamble}, 32'd32, "preamble");
    check({30'h0, mdc, mdioOe}, 32'h0, "line idle");
  endtask : mgmt
  always @(posedge mclk) begin
    if (rdSeen) begin
      if (rq.size() == 0) check(32'h1, 32'h0, "read without note");
      else begin
        note = rq.pop_front();
        if (!note.any) check(regRdData, note.v, "read data");
      end
    end else if (!rst) check(regRdData, 32'h0, "idle read data");
    if (lkSeen || hashAcceptValid !== 1'b0) begin
      check({31'h0, hashAcceptValid}, {31'h0, lkSeen}, "lookup valid");
      if (lkSeen) check({31'h0, hashAccept}, {31'h0, hq.pop_front()}, "lookup");
    end
    rdSeen <= regRd;
    lkSeen <= hashLookup;
  end
  initial begin
    #(30000 * 40);
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    void'($urandom(36));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    foreach (rstAddr[i]) rd(rstAddr[i], rstVal[i]);
    sta(48'hffff_0fffffff);
    $display("test reset values done");
    wr(8'h0c, 32'h11223344);
    rd(8'h0c, 32'h0fffffff);
    for (int i = 1; i <= 7; i++) cfg(8'(i), 8'(8'h12 + 8'h22 * (i - 1)));
    rd(8'h0c, 32'h78563412);
    rd(8'h08, 32'h0000bc9a);
    sta(48'hbc9a_7856_3412);
    @(posedge mclk);
    cfgLoadDone <= 1'b1;
    cfg(8'h01, 8'hff);
    rd(8'h0c, 32'h78563412);
    up = $urandom;
    lo = $urandom;
    wr(8'h0c, up);
    wr(8'h08, lo);
    rd(8'h0c, up);
    rd(8'h08, {16'h0, lo[15:0]});
    sta({lo[15:0], up});
    $display("test station address done");
    wr(8'h10, up);
    wr(8'h14, lo);
    rd(8'h10, up);
    rd(8'h14, lo);
    lookups(up, lo, 1'b0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h1);
    check({31'h0, passAllMulticast}, 32'h1, "pass all");
    lookups(up, lo, 1'b1);
    wr(8'h40, 32'h0);
    wr(8'h10, 32'h0);
    lookups(32'h0, lo, 1'b0);
    $display("test hash filter done");
    d = $urandom;
    tmp = $urandom;
    wr(8'h1c, {16'hffff, d[15:0]});
    rd(8'h1c, {16'h0, d[15:0]});
    mgmt(5'h01, tmp[4:0], 1'b1, {16'h0, d[15:0]}, {4'b0101, 5'h01, tmp[4:0], 2'b10, d[15:0]});
    mgmt(5'h01, tmp[4:0], 1'b0, {16'h0, d[15:0]}, {4'b0110, 5'h01, tmp[4:0], 2'b10, d[15:0]});
    mgmt(5'h02, tmp[4:0], 1'b0, 32'h0000ffff, {4'b0110, 5'h02, tmp[4:0], 2'b11, 16'hffff});
    $display("test phy management done");
    repeat (4) @(posedge mclk);
    stop_test();
  end
endmodule : mahm_regs_test
